// >>> hdl/wdsec_ctrl.sv
// watchdog status, enable and protected write control
// assumes: core gives one-cycle write strobes and an instruction-retire pulse
`timescale 1ns/100ps
`include "wdsec_params.svh"
module wdsec_ctrl #(
    parameter int BASE_CYC = `WDSEC_BASE_CYC
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // core register access
    input  wire wdsec_pkg::wdsec_sfr_s sfr,
    output logic [7:0]             rdata,
    // system events
    input  wire logic              supply_monitor_irq,
    output logic                   sys_reset_req,
    output logic                   wdt_irq,
    output logic                   wdt_irq_high_prio
);

    typedef struct packed {
        wdsec_pkg::wdsec_ctrl_s   ctrl;
        logic                     unlock_live;
        wdsec_pkg::wdsec_state_e  state;
        logic [2:0]               pulse;
        logic                     irq;
        logic [7:0]               rdata;
        logic                     rst_req;
    } wdsec_top_s;

    wdsec_top_s st;
    wdsec_top_s next_st;
    logic       expire;
    logic       count_clear;
    logic       run;
    logic       write_ok;

    // ----------------------------------------
    // interval counter
    // ----------------------------------------
    assign run = st.ctrl.guard_enable_refresh && st.state == wdsec_pkg::WDSEC_ARMED;
    assign count_clear = sfr.wr && write_ok && sfr.wdata[`WDSEC_BIT_ENABLE]; // R5
    assign write_ok = st.unlock_live; // R8

    wdsec_interval_counter #(
        .BASE_CYC (BASE_CYC)
    ) u_cnt (
        .clock    (clock),
        .rst_n    (rst_n),
        .run      (run),
        .clear    (count_clear),
        .prescale (st.ctrl.prescale),
        .expire   (expire)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.irq = 1'b0;
        // unlock lasts only until the next instruction retires
        if (sfr.instr_done) begin
            next_st.unlock_live = 1'b0; // R9
            // readback of the unlock bit follows the permission
            next_st.ctrl.guard_write_unlock = 1'b0; // R9
        end
        if (sfr.wr) begin
            if (write_ok) begin
                next_st.ctrl = wdsec_pkg::wdsec_ctrl_s'(sfr.wdata); // R8
                next_st.ctrl.guard_write_unlock = 1'b0;
                // status only clears via zero write, never sets from software
                next_st.ctrl.timeout_status_flag = st.ctrl.timeout_status_flag
                    & sfr.wdata[`WDSEC_BIT_STATUS]; // R4
                next_st.unlock_live = 1'b0;
            end else if (sfr.wdata == 8'h01 || sfr.wdata[`WDSEC_BIT_UNLOCK]) begin
                // while locked, any write with the unlock bit set sets only the unlock bit
                next_st.ctrl.guard_write_unlock = 1'b1;
                next_st.unlock_live = 1'b1; // R8
            end
        end
        // prescale immediate code forces reset
        if (st.ctrl.guard_enable_refresh && st.ctrl.prescale == `WDSEC_PRE_IMMEDIATE
                && st.state != wdsec_pkg::WDSEC_RESETTING) begin
            next_st.ctrl.timeout_status_flag = 1'b1; // R3
            next_st.state = wdsec_pkg::WDSEC_RESETTING;
            next_st.pulse = 3'(`WDSEC_RST_PULSE_CYC);
        end
        // state machine
        unique case (st.state)
            wdsec_pkg::WDSEC_IDLE: begin
                if (next_st.ctrl.guard_enable_refresh && next_st.state == wdsec_pkg::WDSEC_IDLE) begin
                    next_st.state = wdsec_pkg::WDSEC_ARMED;
                end
            end
            wdsec_pkg::WDSEC_ARMED: begin
                // a period already counted out beats a write in the same cycle
                if (expire) begin
                    next_st.ctrl.timeout_status_flag = 1'b1; // R3
                    if (st.ctrl.timeout_irq_select) begin
                        next_st.irq = 1'b1; // R6 R2
                    end else begin
                        next_st.state = wdsec_pkg::WDSEC_RESETTING; // R6
                        next_st.pulse = 3'(`WDSEC_RST_PULSE_CYC);
                    end
                end else if (!next_st.ctrl.guard_enable_refresh) begin
                    next_st.state = wdsec_pkg::WDSEC_IDLE;
                end
            end
            wdsec_pkg::WDSEC_RESETTING: begin
                // watchdog reset drops enable but keeps the status flag
                next_st.ctrl.guard_enable_refresh = 1'b0; // R7 R4
                if (st.pulse == 3'h1) begin
                    next_st.state = wdsec_pkg::WDSEC_IDLE;
                end
                next_st.pulse = st.pulse - 3'h1;
            end
        endcase
        if (supply_monitor_irq) begin
            next_st.ctrl.guard_enable_refresh = 1'b0; // R7
            if (next_st.state == wdsec_pkg::WDSEC_ARMED) begin
                next_st.state = wdsec_pkg::WDSEC_IDLE;
            end
        end
        next_st.rst_req = next_st.state == wdsec_pkg::WDSEC_RESETTING;
        next_st.rdata = sfr.rd ? 8'(st.ctrl) : 8'h00;
    end

    // state register; hardware reset clears status and enable
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st      <= '0; // R4 R7
            st.ctrl <= wdsec_pkg::wdsec_ctrl_s'(`WDSEC_CTRL_RESET);
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata = st.rdata;
    assign sys_reset_req = st.rst_req;
    assign wdt_irq = st.irq;
    assign wdt_irq_high_prio = st.irq; // R1

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_unlock;
        sfr.wr && !write_ok && sfr.wdata[`WDSEC_BIT_UNLOCK];
    endsequence

    property p_status_set;
        @(posedge clock) disable iff (!rst_n)
        (st.state == wdsec_pkg::WDSEC_ARMED && expire)
            |=> st.ctrl.timeout_status_flag;
    endproperty
    a_status_set: assert property (p_status_set) else $error("status not set on timeout"); // R3

    property p_status_hold;
        @(posedge clock) disable iff (!rst_n)
        (st.ctrl.timeout_status_flag && !(sfr.wr && write_ok)) |=> st.ctrl.timeout_status_flag;
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status cleared unexpectedly"); // R4

    property p_irq_mode;
        @(posedge clock) disable iff (!rst_n)
        wdt_irq |-> (wdt_irq_high_prio && !sys_reset_req);
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq not high priority"); // R1

    property p_reset_mode;
        @(posedge clock) disable iff (!rst_n)
        (st.state == wdsec_pkg::WDSEC_ARMED && expire && !st.ctrl.timeout_irq_select)
            |=> ##1 sys_reset_req;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("no reset on timeout"); // R6

    property p_psm_clear;
        @(posedge clock) disable iff (!rst_n)
        supply_monitor_irq |=> !st.ctrl.guard_enable_refresh;
    endproperty
    a_psm_clear: assert property (p_psm_clear) else $error("enable survives supply irq"); // R7

    property p_locked;
        @(posedge clock) disable iff (!rst_n)
        (sfr.wr && !write_ok && !sfr.wdata[`WDSEC_BIT_UNLOCK] && !supply_monitor_irq
            && st.state == wdsec_pkg::WDSEC_IDLE && !st.ctrl.guard_enable_refresh)
            |=> $stable(st.ctrl.prescale);
    endproperty
    a_locked: assert property (p_locked) else $error("locked write accepted"); // R8

    property p_unlock_lapse;
        @(posedge clock) disable iff (!rst_n)
        s_unlock ##1 (sfr.instr_done && !sfr.wr) |=> !write_ok;
    endproperty
    a_unlock_lapse: assert property (p_unlock_lapse) else $error("unlock did not lapse"); // R9

    property p_refresh_clear;
        @(posedge clock) disable iff (!rst_n)
        count_clear |=> !expire;
    endproperty
    a_refresh_clear: assert property (p_refresh_clear) else $error("counter not cleared"); // R5

    // immediate prescale code resets at once and flags the timeout
    property p_immediate;
        @(posedge clock) disable iff (!rst_n)
        (st.ctrl.guard_enable_refresh && st.ctrl.prescale == `WDSEC_PRE_IMMEDIATE
            && st.state != wdsec_pkg::WDSEC_RESETTING)
            |=> (sys_reset_req && st.ctrl.timeout_status_flag);
    endproperty
    a_immediate: assert property (p_immediate) else $error("no immediate reset"); // R6

endmodule

// >>> hdl/wdsec_interval_counter.sv
// interval counter with a base tick and a power-of-two prescale
// assumes: clear and enable come from the same clock domain
`timescale 1ns/100ps
`include "wdsec_params.svh"
module wdsec_interval_counter #(
    parameter int BASE_CYC = `WDSEC_BASE_CYC
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // control
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [3:0] prescale,
    // event
    output logic            expire
);

    typedef struct packed {
        logic [15:0] base;
        logic [15:0] ticks;
        logic        expire;
    } wdsec_cnt_s;

    wdsec_cnt_s st;
    wdsec_cnt_s next_st;
    logic [15:0] limit;

    // period in base ticks is 2^prescale
    always_comb begin
        limit   = 16'h0001 << prescale[3:0];
        next_st = st;
        next_st.expire = 1'b0;
        if (clear || !run) begin
            next_st.base  = 16'h0000;
            next_st.ticks = 16'h0000;
        end else if (st.base == 16'(BASE_CYC - 1)) begin
            next_st.base = 16'h0000;
            if (st.ticks == limit - 16'h0001) begin
                next_st.ticks  = 16'h0000;
                next_st.expire = 1'b1;
            end else begin
                next_st.ticks = st.ticks + 16'h0001;
            end
        end else begin
            next_st.base = st.base + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expire = st.expire;

endmodule

// >>> hdl/wdsec_params.svh
// constants of the watchdog status and enable block
// assumes: included by the package and by every design file that needs offsets or counts
//
// Behaviour
// [R1] interrupt response has a fixed high priority that software cannot change
// [R2] when not guarding the system the watchdog runs as an interval timer
// [R3] timeout sets the status flag at bit 2 of the control register
// [R4] status flag clears only by software zero write or external hardware reset
// [R5] software setting enable bit 1 enables watchdog and clears its counters
// [R6] missed refresh gives system reset or interrupt per the response select bit
// [R7] enable clears on zero write, watchdog reset, hardware reset, supply monitor irq
// [R8] a write needs the unlock bit set by the immediately preceding instruction
// [R9] unlock permission lapses after the instruction that follows its setting
`ifndef WDSEC_PARAMS_SVH
`define WDSEC_PARAMS_SVH

// ----------------------------------------
// control register bit positions
// ----------------------------------------
`define WDSEC_BIT_UNLOCK     0
`define WDSEC_BIT_ENABLE     1
`define WDSEC_BIT_STATUS     2
`define WDSEC_BIT_IRQ_SEL    3
`define WDSEC_PRE_LSB        4
`define WDSEC_PRE_W          4

// ----------------------------------------
// reset value and prescale codes
// ----------------------------------------
`define WDSEC_CTRL_RESET     8'h10
`define WDSEC_PRE_IMMEDIATE  4'h8
`define WDSEC_PRE_MAX        4'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define WDSEC_CLK_NS         100
`define WDSEC_BASE_US        10
`define WDSEC_BASE_CYC       ((`WDSEC_BASE_US * 1000) / `WDSEC_CLK_NS)
`define WDSEC_RST_PULSE_CYC  4

`endif

// >>> hdl/wdsec_pkg.sv
// types of the watchdog status and enable block
// assumes: compiled before all design modules
`include "wdsec_params.svh"
package wdsec_pkg;

    // ----------------------------------------
    // control register layout
    // ----------------------------------------
    typedef struct packed {
        logic [3:0] prescale;
        logic       timeout_irq_select;
        logic       timeout_status_flag;
        logic       guard_enable_refresh;
        logic       guard_write_unlock;
    } wdsec_ctrl_s;

    // core side special-function access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       instr_done;
        logic [7:0] wdata;
    } wdsec_sfr_s;

    typedef enum logic [1:0] {
        WDSEC_IDLE,
        WDSEC_ARMED,
        WDSEC_RESETTING
    } wdsec_state_e;

endpackage

// >>> verif/tb.sv
// self-checking bench of the watchdog status and enable control
// assumes: design compiled first; short base tick so timeouts take tens of cycles
`timescale 1ns/100ps
module tb;
    // ----------------------------------------
    // signals and bench state
    // ----------------------------------------
    localparam int BASE = 2;
    logic                  clock = 1'b0;
    logic                  rst_n = 1'b0;
    wdsec_pkg::wdsec_sfr_s sfr   = '0;
    logic                  supply_monitor_irq = 1'b0;
    logic [7:0]            rdata;
    logic                  sys_reset_req;
    logic                  wdt_irq;
    logic                  wdt_irq_high_prio;
    logic                  rd_q  = 1'b0;
    logic [7:0]            exp_q[$];
    int                    err_total    = 0;
    int                    total_checks = 0;
    int                    irq_cnt      = 0;
    int                    cyc          = 0;
    int                    seed         = 32'h72BDCA7B;
    int                    n;
    int                    base_cnt;
    logic [7:0]            v;

    always #50 clock = ~clock;

    wdsec_ctrl #(.BASE_CYC(BASE)) i_wdsec_ctrl (
        .clock             (clock),
        .rst_n             (rst_n),
        .sfr               (sfr),
        .rdata             (rdata),
        .supply_monitor_irq(supply_monitor_irq),
        .sys_reset_req     (sys_reset_req),
        .wdt_irq           (wdt_irq),
        .wdt_irq_high_prio (wdt_irq_high_prio)
    );

    // ----------------------------------------
    // compare, verdict and bus tasks
    // ----------------------------------------
    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic results;
        if (err_total == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // single write, no unlock in front
    task automatic wr1(input logic [7:0] d);
        @(posedge clock);
        sfr.wr    <= 1'b1;
        sfr.wdata <= d;
        @(posedge clock);
        sfr.wr    <= 1'b0;
    endtask

    // unlock followed at once by the write
    task automatic wseq(input logic [7:0] d);
        @(posedge clock);
        sfr.wr    <= 1'b1;
        sfr.wdata <= 8'h01;
        @(posedge clock);
        sfr.wdata <= d;
        @(posedge clock);
        sfr.wr    <= 1'b0;
    endtask

    // read request, expectation noted for the monitor
    task automatic rd(input logic [7:0] e);
        @(posedge clock);
        sfr.rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        sfr.rd <= 1'b0;
    endtask

    // wait for the next interrupt pulse, bounded
    task automatic wait_irq;
        n = irq_cnt;
        for (int i = 0; i < 100 && irq_cnt == n; i++) @(negedge clock);
        check("irq_seen", 8'h01, {7'h0, irq_cnt != n});
    endtask

    // wait for a watchdog reset request and count how long it stands
    task automatic rst_len;
        for (int i = 0; i < 100 && sys_reset_req !== 1'b1; i++) @(negedge clock);
        n = 0;
        while (sys_reset_req === 1'b1 && n < 10) begin
            n++;
            @(negedge clock);
        end
        check("rst_len", 8'h04, 8'(n));
    endtask

    // ----------------------------------------
    // output monitor and cycle limit
    // ----------------------------------------
    always @(posedge clock) begin
        rd_q <= sfr.rd;
        cyc  <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end

    always @(negedge clock) begin
        if (rd_q === 1'b1) check("rdata", exp_q.pop_front(), rdata);
        if (wdt_irq === 1'b1) begin
            irq_cnt++;
            check("irq_prio", 8'h01, {7'h0, wdt_irq_high_prio});
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(8'h10);
        // unsequenced random writes are ignored
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            v[0] = 1'b0;
            wr1(v);
            rd(8'h10);
        end
        // unlock lapses once an instruction retires
        wr1(8'h01);
        sfr.instr_done <= 1'b1;
        @(posedge clock);
        sfr.instr_done <= 1'b0;
        wr1(8'h32);
        rd(8'h10);
        // interrupt mode, refreshed in time
        wseq(8'h3A);
        rd(8'h3A);
        base_cnt = irq_cnt;
        for (int i = 0; i < 6; i++) begin
            wseq(8'h3A);
            repeat (6) @(posedge clock);
        end
        check("no_irq", 8'h00, 8'(irq_cnt - base_cnt));
        wait_irq();
        rd(8'h3E);
        wait_irq();
        wseq(8'h38);
        rd(8'h38);
        // reset mode: four-cycle request, enable drops, status stays
        wseq(8'h32);
        rst_len();
        rd(8'h34);
        // external hardware reset clears both bits
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd(8'h10);
        // supply monitor interrupt clears enable
        wseq(8'h32);
        @(posedge clock);
        supply_monitor_irq <= 1'b1;
        @(posedge clock);
        supply_monitor_irq <= 1'b0;
        rd(8'h30);
        // immediate prescale code: reset at once, status set, enable dropped
        wseq(8'h82);
        rst_len();
        rd(8'h84);
        repeat (3) @(posedge clock);
        results();
    end
endmodule
